/* File: hdl/dual_uart_with_flow_control.sv */
`timescale 1ns/10ps
module dual_uart_with_flow_control import uart_pair_pkg::*; #(
	parameter int DEPTH     = BUF_DEPTH,
	parameter int DIV_LIMIT = DIV_MAX
) (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	output logic             irq,
	output logic             serial_tx_line_one,
	input  wire logic        serial_rx_line_one,
	output logic             serial_tx_line_two,
	input  wire logic        serial_rx_line_two,
	output logic             port_two_request_to_send_n,
	input  wire logic        port_two_clear_to_send_n
);

	localparam int PW = $clog2(DEPTH);
	localparam logic [15:0] DIV_LO = 16'(DIV_MIN);
	localparam logic [15:0] DIV_HI = 16'(DIV_LIMIT);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || DIV_LIMIT > 65535 ||
			DIV_LIMIT < DIV_MIN) begin : g_bad_param
			$error("unsupported DEPTH or DIV_LIMIT");
		end
	endgenerate

	typedef struct packed {
		logic                  en;
		logic                  par_en;
		logic                  par_odd;
		logic                  irq_mode;
		logic [15:0]           div;
		logic [EV_WIDTH-1:0]   ist;
		logic [EV_WIDTH-1:0]   imask;
		logic [DEPTH-1:0][7:0] txb;
		logic [DEPTH-1:0][7:0] rxb;
		logic [PW:0]           tx_wr;
		logic [PW:0]           tx_rd;
		logic [PW:0]           rx_wr;
		logic [PW:0]           rx_rd;
		tx_state_t             txs;
		logic [15:0]           txc;
		logic [2:0]            txi;
		logic [7:0]            txsh;
		logic                  tx_line;
		rx_state_t             rxs;
		logic [15:0]           rxc;
		logic [2:0]            rxi;
		logic [7:0]            rxsh;
		logic                  rxpar;
		logic [1:0]            rx_sync;
	} port_t;

	typedef struct packed {
		port_t [1:0] p;
		logic [1:0]  cts_sync;
		logic        rts_n;
		logic        wr_pend;
		logic [7:0]  wr_addr;
		logic [31:0] rdata;
		logic        irq;
	} state_t;

	state_t s;
	state_t n;

	logic [1:0] tx_full;
	logic [1:0] tx_empty;
	logic [1:0] rx_full;
	logic [1:0] rx_empty;
	logic [1:0] rx_in;
	logic       acc;

	function automatic logic buf_full(input logic [PW:0] wr, input logic [PW:0] rd);
		return (wr[PW] != rd[PW]) && (wr[PW-1:0] == rd[PW-1:0]);
	endfunction

	// offsets above the port windows read zero and ignore writes
	function automatic logic reg_hit(input logic [7:0] a);
		return a[7:6] == 2'b00 && a[1:0] == 2'b00 && a[4:0] <= OFF_IMASK;
	endfunction

	function automatic logic parity_of(input logic [7:0] d, input logic odd);
		return (^d) ^ odd;
	endfunction

	assign rx_in = {serial_rx_line_two, serial_rx_line_one};
	assign acc   = hsel && hready && htrans[1];

	// RULE_01 separate state per port
	generate
		for (genvar g = 0; g < 2; g++) begin : g_flags
			assign tx_full[g]  = buf_full(s.p[g].tx_wr, s.p[g].tx_rd);
			assign tx_empty[g] = s.p[g].tx_wr == s.p[g].tx_rd;
			assign rx_full[g]  = buf_full(s.p[g].rx_wr, s.p[g].rx_rd);
			assign rx_empty[g] = s.p[g].rx_wr == s.p[g].rx_rd;
		end
	endgenerate

	always_comb begin
		logic [EV_WIDTH-1:0] set;
		logic [EV_WIDTH-1:0] clr;
		logic                bit_end;
		logic                rxb_now;
		set     = '0;
		clr     = '0;
		bit_end = 1'b0;
		rxb_now = 1'b0;
		n = s;
		n.wr_pend  = acc && hwrite && hsize == HSIZE_WORD;
		n.wr_addr  = haddr[7:0];
		n.rdata    = '0;
		n.irq      = 1'b0;
		n.cts_sync = {s.cts_sync[0], port_two_clear_to_send_n};
		// RULE_08 request low while able to accept
		// RULE_09 request high when full or disabled
		n.rts_n    = !(s.p[1].en && !rx_full[1]);
		for (int i = 0; i < 2; i++) begin
			set = '0;
			clr = '0;
			n.p[i].rx_sync = {s.p[i].rx_sync[0], rx_in[i]};
			rxb_now = s.p[i].rx_sync[1];

			// reads act in the address phase so a pop lines up with its data
			if (acc && !hwrite && reg_hit(haddr[7:0]) && haddr[PORT_BIT] == 1'(i)) begin
				unique case (haddr[4:0])
					OFF_CTRL: begin
						n.rdata[CTRL_EN]       = s.p[i].en;
						n.rdata[CTRL_PAR_EN]   = s.p[i].par_en;
						n.rdata[CTRL_PAR_ODD]  = s.p[i].par_odd;
						n.rdata[CTRL_IRQ_MODE] = s.p[i].irq_mode;
					end
					OFF_DIV: n.rdata[15:0] = s.p[i].div;
					OFF_RXDATA: begin
						if (!rx_empty[i]) begin
							n.rdata[7:0]  = s.p[i].rxb[s.p[i].rx_rd[PW-1:0]];
							n.p[i].rx_rd  = (PW+1)'(s.p[i].rx_rd + 1'b1);
						end
					end
					OFF_STATUS: begin
						n.rdata[ST_TX_EMPTY] = tx_empty[i];
						n.rdata[ST_TX_FULL]  = tx_full[i];
						n.rdata[ST_RX_EMPTY] = rx_empty[i];
						n.rdata[ST_RX_FULL]  = rx_full[i];
						n.rdata[ST_TX_BUSY]  = s.p[i].txs != TX_IDLE;
						n.rdata[ST_RX_BUSY]  = s.p[i].rxs != RX_IDLE;
					end
					OFF_IST:   n.rdata[EV_WIDTH-1:0] = s.p[i].ist;
					OFF_IMASK: n.rdata[EV_WIDTH-1:0] = s.p[i].imask;
					default: ;
				endcase
			end

			// writes act in the data phase, when hwdata stands
			if (s.wr_pend && reg_hit(s.wr_addr) && s.wr_addr[PORT_BIT] == 1'(i)) begin
				unique case (s.wr_addr[4:0])
					OFF_CTRL: begin
						n.p[i].en       = hwdata[CTRL_EN];
						n.p[i].par_en   = hwdata[CTRL_PAR_EN];
						n.p[i].par_odd  = hwdata[CTRL_PAR_ODD];
						// RULE_02 polling or interrupt
						n.p[i].irq_mode = hwdata[CTRL_IRQ_MODE];
					end
					// RULE_03 clamp to legal range
					OFF_DIV: begin
						if (hwdata[15:0] < DIV_LO)
							n.p[i].div = DIV_LO;
						else if (hwdata[15:0] > DIV_HI)
							n.p[i].div = DIV_HI;
						else
							n.p[i].div = hwdata[15:0];
					end
					// a write to a full buffer is dropped
					OFF_TXDATA: begin
						if (!tx_full[i]) begin
							n.p[i].txb[s.p[i].tx_wr[PW-1:0]] = hwdata[7:0];
							n.p[i].tx_wr = (PW+1)'(s.p[i].tx_wr + 1'b1);
						end
					end
					OFF_IST:   clr = hwdata[EV_WIDTH-1:0];
					OFF_IMASK: n.p[i].imask = hwdata[EV_WIDTH-1:0];
					default: ;
				endcase
			end

			// transmitter
			bit_end = s.p[i].txc == s.p[i].div - 16'h1;
			if (!s.p[i].en) begin
				n.p[i].txs     = TX_IDLE;
				n.p[i].tx_line = 1'b1;
			end else begin
				unique case (s.p[i].txs)
					TX_IDLE: begin
						n.p[i].tx_line = 1'b1;
						// RULE_07 port one ignores flow control
						// RULE_10 wait for clear-to-send low
						if (!tx_empty[i] && (i == 0 || !s.cts_sync[1])) begin
							// RULE_05 byte from buffer memory
							n.p[i].txsh    = s.p[i].txb[s.p[i].tx_rd[PW-1:0]];
							n.p[i].tx_rd   = (PW+1)'(s.p[i].tx_rd + 1'b1);
							n.p[i].txs     = TX_START;
							n.p[i].txc     = '0;
							// RULE_04 low start bit
							n.p[i].tx_line = 1'b0;
						end
					end
					TX_START: begin
						n.p[i].txc = bit_end ? 16'h0 : 16'(s.p[i].txc + 1'b1);
						if (bit_end) begin
							n.p[i].txs     = TX_DATA;
							n.p[i].txi     = '0;
							n.p[i].tx_line = s.p[i].txsh[0];
						end
					end
					TX_DATA: begin
						n.p[i].txc = bit_end ? 16'h0 : 16'(s.p[i].txc + 1'b1);
						if (bit_end) begin
							if (s.p[i].txi == 3'h7) begin
								n.p[i].txs = TX_PAR_STOP;
								// RULE_12 parity bit or stop bit
								n.p[i].tx_line = s.p[i].par_en ?
									parity_of(s.p[i].txsh, s.p[i].par_odd) : 1'b1;
							end else begin
								n.p[i].txi     = 3'(s.p[i].txi + 1'b1);
								n.p[i].tx_line = s.p[i].txsh[3'(s.p[i].txi + 1'b1)];
							end
						end
					end
					TX_PAR_STOP: begin
						n.p[i].txc = bit_end ? 16'h0 : 16'(s.p[i].txc + 1'b1);
						if (bit_end) begin
							// RULE_04 parity then one high stop bit
							if (s.p[i].par_en && s.p[i].txi == 3'h7) begin
								n.p[i].txi     = '0;
								n.p[i].tx_line = 1'b1;
							end else begin
								n.p[i].txs            = TX_IDLE;
								n.p[i].tx_line        = 1'b1;
								set[EV_TX_DONE]       = 1'b1;
							end
						end
					end
				endcase
			end

			// receiver
			bit_end = s.p[i].rxc == s.p[i].div - 16'h1;
			if (!s.p[i].en) begin
				n.p[i].rxs = RX_IDLE;
			end else begin
				unique case (s.p[i].rxs)
					RX_IDLE: begin
						if (!rxb_now) begin
							n.p[i].rxs = RX_START;
							n.p[i].rxc = '0;
						end
					end
					// sample mid start bit; a short glitch is not a start
					RX_START: begin
						n.p[i].rxc = 16'(s.p[i].rxc + 1'b1);
						if (s.p[i].rxc == (s.p[i].div >> 1)) begin
							n.p[i].rxc = '0;
							n.p[i].rxi = '0;
							n.p[i].rxs = rxb_now ? RX_IDLE : RX_DATA;
						end
					end
					RX_DATA: begin
						n.p[i].rxc = bit_end ? 16'h0 : 16'(s.p[i].rxc + 1'b1);
						if (bit_end) begin
							n.p[i].rxsh[s.p[i].rxi] = rxb_now;
							n.p[i].rxi              = 3'(s.p[i].rxi + 1'b1);
							if (s.p[i].rxi == 3'h7)
								n.p[i].rxs = s.p[i].par_en ? RX_PAR : RX_STOP;
						end
					end
					RX_PAR: begin
						n.p[i].rxc = bit_end ? 16'h0 : 16'(s.p[i].rxc + 1'b1);
						if (bit_end) begin
							n.p[i].rxpar = rxb_now;
							n.p[i].rxs   = RX_STOP;
						end
					end
					RX_STOP: begin
						n.p[i].rxc = bit_end ? 16'h0 : 16'(s.p[i].rxc + 1'b1);
						if (bit_end) begin
							n.p[i].rxs = RX_IDLE;
							if (!rxb_now) begin
								set[EV_FRM_ERR] = 1'b1;
							end else if (rx_full[i]) begin
								set[EV_OVERRUN] = 1'b1;
							end else begin
								// RULE_06 store byte in buffer memory
								n.p[i].rxb[s.p[i].rx_wr[PW-1:0]] = s.p[i].rxsh;
								n.p[i].rx_wr = (PW+1)'(s.p[i].rx_wr + 1'b1);
								set[EV_RX_RDY] = 1'b1;
								// RULE_12 parity check on receive
								if (s.p[i].par_en &&
									s.p[i].rxpar != parity_of(s.p[i].rxsh, s.p[i].par_odd))
									set[EV_PAR_ERR] = 1'b1;
							end
						end
					end
					default: n.p[i].rxs = RX_IDLE;
				endcase
			end

			// a new event beats a clear in the same cycle
			n.p[i].ist = (s.p[i].ist & ~clr) | set;
			// RULE_02 only interrupt mode raises the line
			if (s.p[i].irq_mode && |(s.p[i].ist & s.p[i].imask))
				n.irq = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s <= '0;
			s.rts_n <= 1'b1;
			s.cts_sync <= 2'b11;
			for (int i = 0; i < 2; i++) begin
				s.p[i].div     <= 16'(DIV_RESET);
				s.p[i].tx_line <= 1'b1;
				s.p[i].rx_sync <= 2'b11;
			end
		end else begin
			s <= n;
		end
	end

	assign hreadyout                  = 1'b1;
	assign hresp                      = 1'b0;
	assign hrdata                     = s.rdata;
	assign irq                        = s.irq;
	assign serial_tx_line_one         = s.p[0].tx_line;
	assign serial_tx_line_two         = s.p[1].tx_line;
	assign port_two_request_to_send_n = s.rts_n;

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	rts_blocked_a: assert property ( // RULE_09
		(!s.p[1].en || rx_full[1]) |=> port_two_request_to_send_n
	) else $error("request-to-send low while unable to accept");

	rts_ready_a: assert property ( // RULE_08
		(s.p[1].en && !rx_full[1]) |=> !port_two_request_to_send_n
	) else $error("request-to-send high while able to accept");

	cts_gate_a: assert property ( // RULE_10
		(s.p[1].txs == TX_IDLE ##1 s.p[1].txs == TX_START) |-> $past(s.cts_sync[1]) == 1'b0
	) else $error("port two started without clear-to-send");

	port_one_free_a: assert property ( // RULE_07
		(s.p[0].en && s.p[0].txs == TX_IDLE && !tx_empty[0]) |=> s.p[0].txs == TX_START
	) else $error("port one did not start with data pending");

	tx_pop_a: assert property ( // RULE_05
		(s.p[0].txs == TX_START && $past(s.p[0].txs) == TX_IDLE) |->
			s.p[0].tx_rd == (PW+1)'($past(s.p[0].tx_rd) + 1'b1) && !serial_tx_line_one
	) else $error("start bit without buffer pop");

	bit_time_a: assert property ( // RULE_03
		s.p[1].txs != TX_IDLE |-> s.p[1].txc < s.p[1].div
			&& s.p[1].div >= DIV_LO && s.p[1].div <= DIV_HI
	) else $error("bit counter or divisor out of range");

	data_bit_a: assert property ( // RULE_04
		s.p[0].txs == TX_DATA |-> serial_tx_line_one == s.p[0].txsh[s.p[0].txi]
	) else $error("data bit on line does not match shift byte");

	rx_store_a: assert property ( // RULE_06
		s.p[0].rx_wr != $past(s.p[0].rx_wr) |->
			$past(s.p[0].rxs) == RX_STOP && s.p[0].ist[EV_RX_RDY]
	) else $error("receive store outside stop bit");

	irq_level_a: assert property ( // RULE_02
		(s.p[0].irq_mode && |(s.p[0].ist & s.p[0].imask)) |=> irq
	) else $error("interrupt not raised");

	parity_out_a: assert property ( // RULE_12
		(s.p[0].txs == TX_PAR_STOP && s.p[0].par_en && s.p[0].txi == 3'h7) |->
			serial_tx_line_one == parity_of(s.p[0].txsh, s.p[0].par_odd)
	) else $error("wrong transmit parity");

endmodule // dual_uart_with_flow_control

/* File: hdl/uart_pair_pkg.sv */
// How it works
// RULE_01: two independent ports, each its own lines
// RULE_02: per-port polling or interrupt mode select
// RULE_03: bit rate programmable, 2.4 kbps to 2.4 Mbps
// RULE_04: start, eight data, optional parity, stop
// RULE_05: transmit bytes from buffer memory, serially
// RULE_06: received bytes stored into buffer memory
// RULE_07: only port two uses flow control
// RULE_08: port two drives request low when ready
// RULE_09: request high when receive full or disabled
// RULE_10: port two starts a character only when cleared
// RULE_11: peer raises its request only when ready
// RULE_12: parity generated on send, checked on receive
package uart_pair_pkg;

	localparam int CLK_HZ    = 40_000_000;
	localparam int BAUD_MIN  = 2_400;
	localparam int BAUD_MAX  = 2_400_000;
	localparam int BAUD_DEF  = 115_200;
	// longest bit period rounds down, shortest rounds up
	localparam int DIV_MAX   = CLK_HZ / BAUD_MIN;
	localparam int DIV_MIN   = (CLK_HZ + BAUD_MAX - 1) / BAUD_MAX;
	localparam int DIV_RESET = CLK_HZ / BAUD_DEF;
	localparam int BUF_DEPTH = 8;

	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// register offsets within one port's window
	localparam logic [4:0] OFF_CTRL   = 5'h00;
	localparam logic [4:0] OFF_DIV    = 5'h04;
	localparam logic [4:0] OFF_TXDATA = 5'h08;
	localparam logic [4:0] OFF_RXDATA = 5'h0C;
	localparam logic [4:0] OFF_STATUS = 5'h10;
	localparam logic [4:0] OFF_IST    = 5'h14;
	localparam logic [4:0] OFF_IMASK  = 5'h18;
	localparam int         PORT_BIT   = 5;

	// control fields
	localparam int CTRL_EN       = 0;
	localparam int CTRL_PAR_EN   = 1;
	localparam int CTRL_PAR_ODD  = 2;
	localparam int CTRL_IRQ_MODE = 3;

	// status fields
	localparam int ST_TX_EMPTY = 0;
	localparam int ST_TX_FULL  = 1;
	localparam int ST_RX_EMPTY = 2;
	localparam int ST_RX_FULL  = 3;
	localparam int ST_TX_BUSY  = 4;
	localparam int ST_RX_BUSY  = 5;

	// event bits, shared by status and mask
	localparam int EV_WIDTH   = 5;
	localparam int EV_TX_DONE = 0;
	localparam int EV_RX_RDY  = 1;
	localparam int EV_PAR_ERR = 2;
	localparam int EV_FRM_ERR = 3;
	localparam int EV_OVERRUN = 4;

	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR_STOP} tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

endpackage

/* File: tb/dual_uart_with_flow_control_tb.sv */
`timescale 1ns/10ps
module dual_uart_with_flow_control_tb import uart_pair_pkg::*; ;
	localparam int          DIV_T = 20;
	localparam int          LIMIT = 40000;
	localparam logic [31:0] P2    = 32'h20;
	typedef struct {
		logic        w;
		logic [31:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} row_t;
	logic        clock;
	logic        sys_rst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        irq;
	logic        tx_one;
	logic        rx_one;
	logic        tx_two;
	logic        rx_two;
	logic        rts_n;
	logic        cts_n;
	logic [31:0] q;
	int          n_mismatch;
	int          checks;
	int          cyc;
	int          n;
	row_t        rows[15];

	dual_uart_with_flow_control #(.DEPTH(2), .DIV_LIMIT(64)) i_dut (
		.clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
		.serial_tx_line_one(tx_one), .serial_rx_line_one(rx_one),
		.serial_tx_line_two(tx_two), .serial_rx_line_two(rx_two),
		.port_two_request_to_send_n(rts_n), .port_two_clear_to_send_n(cts_n));
	serial_peer #(.DIV(DIV_T)) p1 (.clock(clock), .tx_in(tx_one), .rts_n(1'b0),
		.rx_out(rx_one), .cts_n());
	serial_peer #(.DIV(DIV_T)) p2 (.clock(clock), .tx_in(tx_two), .rts_n(rts_n),
		.rx_out(rx_two), .cts_n(cts_n));

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	task automatic close_out();
		$display("checks=%0d mismatches=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_mismatch++;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// hready sampled at the rising edge, read data taken at that same edge
	task automatic rdy();
		do begin
			@(posedge clock);
		end while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
	endtask

	task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk(q, e);
	endtask

	initial begin
		sys_rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0;
		n_mismatch = 0;
		checks = 0;
		cyc = 0;
		rows = '{
			'{1'b0, 32'h00, 32'h0, 32'h0}, '{1'b0, 32'h04, 32'h0, 32'h15B},
			'{1'b0, 32'h10, 32'h0, 32'h5}, '{1'b0, 32'h30, 32'h0, 32'h5},
			'{1'b0, 32'h14, 32'h0, 32'h0}, '{1'b0, 32'h18, 32'h0, 32'h0},
			'{1'b0, 32'h0C, 32'h0, 32'h0}, '{1'b0, 32'h1C, 32'h0, 32'h0},
			'{1'b1, 32'h1C, 32'hFF, 32'h0}, '{1'b1, 32'h04, 32'h5, 32'h11},
			'{1'b1, 32'h04, 32'hFFFF, 32'h40}, '{1'b1, 32'h04, 32'h14, 32'h14},
			'{1'b1, 32'h24, 32'h14, 32'h14}, '{1'b1, 32'h18, 32'h1F, 32'h1F},
			'{1'b1, 32'h14, 32'h1F, 32'h0}};
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		foreach (rows[i]) begin
			if (rows[i].w) ahb(1'b1, rows[i].a, rows[i].d);
			rdchk(rows[i].a, rows[i].e);
		end
		chk({27'h0, hresp, irq, tx_one, tx_two, rts_n}, 32'h7);
		// port one ignores a held clear-to-send
		p2.cts_n <= 1'b1;
		ahb(1'b1, OFF_CTRL, 32'h1);
		ahb(1'b1, OFF_TXDATA, 32'hA5);
		ahb(1'b1, OFF_TXDATA, 32'h5A);
		for (n = 0; n < 3000 && p1.got.size() < 2; n++) @(posedge clock);
		chk(32'(p1.got[0]), 32'hA5);
		chk(32'(p1.got[1]), 32'h5A);
		chk(32'(irq), 32'h0);
		p1.send(8'h3C, 1'b0, 1'b0);
		rdchk(OFF_IST, 32'h3);
		rdchk(OFF_RXDATA, 32'h3C);
		// third byte into a full buffer is dropped as an overrun
		for (int i = 1; i < 4; i++) p1.send(8'(i), 1'b0, 1'b0);
		rdchk(OFF_IST, 32'h13);
		rdchk(OFF_RXDATA, 32'h1);
		rdchk(OFF_RXDATA, 32'h2);
		// port two, odd parity, interrupt mode
		p2.par_on = 1'b1;
		p2.par_odd = 1'b1;
		ahb(1'b1, P2 + OFF_IMASK, 32'h6);
		ahb(1'b1, P2 + OFF_CTRL, 32'hF);
		rdchk(P2 + OFF_STATUS, 32'h5);
		chk(32'(rts_n), 32'h0);
		ahb(1'b1, P2 + OFF_TXDATA, 32'h96);
		repeat (300) @(posedge clock);
		chk(32'(tx_two), 32'h1);
		rdchk(P2 + OFF_STATUS, 32'h4);
		p2.cts_n <= 1'b0;
		for (n = 0; n < 3000 && p2.got.size() < 1; n++) @(posedge clock);
		chk(32'(p2.got[0]), 32'h96);
		chk(32'(p2.got_par[0]), 32'(~^8'h96));
		p2.send(8'h81, 1'b1, 1'b0);
		rdchk(P2 + OFF_IST, 32'h7);
		chk(32'(irq), 32'h1);
		rdchk(P2 + OFF_RXDATA, 32'h81);
		ahb(1'b1, P2 + OFF_IST, 32'h7);
		rdchk(P2 + OFF_IST, 32'h0);
		chk(32'(irq), 32'h0);
		p2.send(8'h11, 1'b0, 1'b0);
		p2.send(8'h22, 1'b0, 1'b0);
		chk(32'(rts_n), 32'h1);
		rdchk(P2 + OFF_RXDATA, 32'h11);
		@(posedge clock);
		chk(32'(rts_n), 32'h0);
		p2.send(8'h33, 1'b0, 1'b1);
		rdchk(P2 + OFF_IST, 32'hA);
		rdchk(P2 + OFF_RXDATA, 32'h22);
		rdchk(P2 + OFF_RXDATA, 32'h0);
		ahb(1'b1, P2 + OFF_CTRL, 32'h0);
		// disable lands at this edge, request follows one edge later
		repeat (2) @(posedge clock);
		chk(32'(rts_n), 32'h1);
		// mid-run reset brings registers back to reset values
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		chk({27'h0, hresp, irq, tx_one, tx_two, rts_n}, 32'h7);
		rdchk(P2 + OFF_DIV, 32'h15B);
		rdchk(OFF_STATUS, 32'h5);
		close_out();
	end
endmodule // dual_uart_with_flow_control_tb

/* File: tb/serial_peer.sv */
`timescale 1ns/10ps
module serial_peer #(
	parameter int DIV = 20
) (
	input  wire logic clock,
	input  wire logic tx_in,
	input  wire logic rts_n,
	output logic      rx_out,
	output logic      cts_n
);
	logic [7:0] got[$];
	logic       got_par[$];
	logic       par_on;
	logic       par_odd;
	logic [7:0] sh;

	initial begin
		rx_out = 1'b1;
		cts_n = 1'b0;
		par_on = 1'b0;
		par_odd = 1'b0;
	end

	task automatic bit_out(input logic v);
		rx_out <= v;
		repeat (DIV) @(posedge clock);
	endtask

	task automatic send(input logic [7:0] b, input logic bad_par, input logic bad_stop);
		// no frame until the receiver asks for one; the bench timeout ends a hang
		while (rts_n !== 1'b0) @(posedge clock);
		@(posedge clock);
		bit_out(1'b0);
		for (int i = 0; i < 8; i++) bit_out(b[i]);
		if (par_on) bit_out(^b ^ par_odd ^ bad_par);
		// a bad stop is cut short so the line is high again before idle resumes
		rx_out <= ~bad_stop;
		repeat (DIV / 2 + 4) @(posedge clock);
		bit_out(1'b1);
	endtask

	// capture, lsb first, stop must be high
	always begin
		@(negedge tx_in);
		repeat (DIV / 2) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (DIV) @(posedge clock);
			sh[i] = tx_in;
		end
		if (par_on) begin
			repeat (DIV) @(posedge clock);
			got_par.push_back(tx_in);
		end
		repeat (DIV) @(posedge clock);
		if (tx_in) got.push_back(sh);
	end
endmodule // serial_peer
